// ===== common/rt_pointer_pkg.sv
// constants and register map for the remote terminal pointer block engine
// Overview of operation
// [R01] Overrun detection sets status bit zero
// [R02] Status read clears overrun unless still present
// [R03] Capture valid commands except 1553B transmit-last-command
// [R04] Last command register resets to 0410 hex
// [R05] Last command fields: address, direction, subaddress, count
// [R06] Stop self-test write halts all memory activity
// [R07] Stop self-test clears enable and active bits
// [R08] Stop self-test write data is ignored
// [R09] Data moves through 64K-word shared memory
// [R10] Host programs base config and pointer block first
// [R11] Host leaves base config alone during messages
// [R12] Config upper ten bits form address 15:6
// [R13] Low six bits from direction and subaddress
// [R14] Low bits forced: command, single mode, mode code
// [R15] Command word written to pointer slot zero
// [R16] Single mode receive uses and updates slot 31
// [R17] Mode data: pointer slot 32, low four code bits
// [R18] Transmit uses slots 33-62, pointer increments per word
// [R19] Mode bit one selects single receive buffer; the code uses base config bit 4
// [R20] Size exponent 3..15 gives 8..32K word buffers
// [R21] Size applies to single or every separate buffer
// [R22] Host sizes buffers for the longest message
package rt_pointer_pkg;
  // register indices; byte offset is index times four
  localparam logic [2:0] IDX_STATUS = 3'h0;
  localparam logic [2:0] IDX_LASTCMD = 3'h1;
  localparam logic [2:0] IDX_SST = 3'h2;
  localparam logic [2:0] IDX_PBC = 3'h3;
  localparam logic [2:0] IDX_CTL = 3'h4;
  localparam int IDX_LSB = 2;
  // status and control bit positions
  localparam int STAT_OVERRUN = 0;
  localparam int STAT_BMODE = 6;
  localparam int STAT_ST_ACTIVE = 11;
  localparam int STAT_MSG_ACTIVE = 15;
  localparam int CTL_ST_ENABLE = 0;
  localparam int CTL_BMODE = 1;
  // base config fields
  localparam int PBC_BASE_LSB = 6;
  localparam int PBC_SINGLE = 4;
  localparam int PBC_SIZE_MSB = 3;
  // reset values
  localparam logic [15:0] LASTCMD_RESET = 16'h0410;
  localparam logic [15:0] PBC_RESET = 16'h0000;
  // command word fields
  localparam int CMD_TR = 10;
  localparam int CMD_SA_MSB = 9;
  localparam int CMD_SA_LSB = 5;
  localparam int CMD_MC_MSB = 4;
  localparam logic [4:0] MODE_SA_LO = 5'h00;
  localparam logic [4:0] MODE_SA_HI = 5'h1f;
  localparam logic [4:0] MC_TX_LAST_CMD = 5'h12;
  // pointer block slots
  localparam logic [5:0] SLOT_CMD = 6'h00;
  localparam logic [5:0] SLOT_SINGLE = 6'h1f;
  localparam logic [5:0] SLOT_MODE = 6'h20;
  localparam logic [3:0] BSIZE_MIN = 4'h3;
  localparam logic [5:0] MAX_WORDS = 6'h20;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_CMD_WR = 3'b001,
    ST_PTR_RD = 3'b010,
    ST_XFER = 3'b011,
    ST_PTR_WR = 3'b100
  } dma_state_e;
endpackage : rt_pointer_pkg

// ===== core/rt_pointer_block_addressing.sv
// pointer block address generation, dma sequencing and axi registers
`timescale 1ns/1ns
module rt_pointer_block_addressing
  import rt_pointer_pkg::*;
#(
  parameter int ADDR_W = 5
)
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // decoded bus traffic
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  input wire logic overrun_detect,
  input wire logic rx_word_valid,
  input wire logic [15:0] rx_word,
  output logic rx_word_ready,
  output logic tx_word_valid,
  output logic [15:0] tx_word,
  // shared memory dma master
  output logic dma_req,
  output logic dma_we,
  output logic [15:0] dma_addr,
  output logic [15:0] dma_wdata,
  input wire logic dma_ack,
  input wire logic [15:0] dma_rdata
);
  if (ADDR_W < 5) begin : g_bad_addr_w
    $error("ADDR_W too small for register map");
  end

  function automatic logic [2:0] reg_idx(input logic [ADDR_W-1:0] a);
    reg_idx = a[IDX_LSB+2:IDX_LSB];
  endfunction : reg_idx

  function automatic logic is_mode(input logic [15:0] c);
    is_mode = c[CMD_SA_MSB:CMD_SA_LSB] == MODE_SA_LO ||
              c[CMD_SA_MSB:CMD_SA_LSB] == MODE_SA_HI;
  endfunction : is_mode

  // exponents below the minimum are served as the minimum buffer
  function automatic logic [15:0] ring_inc(input logic [15:0] p,
                                           input logic [3:0] e);
    logic [3:0] x;
    logic [15:0] m;
    x = (e < BSIZE_MIN) ? BSIZE_MIN : e;
    m = 16'((32'h1 << x) - 32'h1);
    ring_inc = (p & ~m) | ((p + 16'h1) & m);
  endfunction : ring_inc

  logic aw_have_reg, w_have_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic [15:0] w_data_reg;
  logic [1:0] w_strb_reg;
  logic [15:0] last_command_reg, pointer_base_config_reg, cur_cmd_reg;
  logic overrun_reg, self_test_enable_reg, self_test_active_reg;
  logic b_mode_reg;
  dma_state_e state_reg;
  logic [15:0] work_ptr_reg;
  logic [5:0] words_left_reg;
  logic [15:0] status_word;
  logic [9:0] block_base;
  logic single_mode;
  logic [3:0] size_exp;
  logic wr_fire, ar_take, sst_hit, cmd_take, cmd_is_tlc;
  logic cur_mode, cur_tx, cur_need_ptr, cur_wb;
  logic [5:0] cur_slot;

  assign block_base = pointer_base_config_reg[15:PBC_BASE_LSB];
  assign single_mode = pointer_base_config_reg[PBC_SINGLE];
  assign size_exp = pointer_base_config_reg[PBC_SIZE_MSB:0];
  assign wr_fire = aw_have_reg && w_have_reg && !bvalid;
  assign ar_take = arvalid && arready;
  // write data is never looked at, only the access itself
  assign sst_hit = wr_fire && reg_idx(aw_addr_reg) == IDX_SST; // R08
  assign cmd_take = cmd_valid && state_reg == ST_IDLE && !sst_hit;
  assign cmd_is_tlc = b_mode_reg && cmd_word[CMD_TR] && is_mode(cmd_word)
                      && cmd_word[CMD_MC_MSB:0] == MC_TX_LAST_CMD;
  assign cur_mode = is_mode(cur_cmd_reg);
  assign cur_tx = cur_cmd_reg[CMD_TR];
  // mode codes with data exist only in 1553B mode
  assign cur_need_ptr = !cur_mode || (b_mode_reg && cur_cmd_reg[CMD_MC_MSB]);
  assign cur_wb = !cur_mode && !cur_tx;

  always_comb
  begin
    if (cur_mode)
      cur_slot = SLOT_MODE; // R14 R17
    else if (!cur_tx && single_mode)
      cur_slot = SLOT_SINGLE; // R16 R19
    else
      cur_slot = cur_cmd_reg[CMD_TR:CMD_SA_LSB]; // R13 R18
  end

  always_comb
  begin
    status_word = 16'h0000;
    status_word[STAT_OVERRUN] = overrun_reg;
    status_word[STAT_BMODE] = b_mode_reg;
    status_word[STAT_ST_ACTIVE] = self_test_active_reg;
    status_word[STAT_MSG_ACTIVE] = state_reg != ST_IDLE;
  end

  // axi write channels, taken in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      aw_have_reg <= 1'b0;
      w_have_reg <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= 16'h0000;
      w_strb_reg <= 2'h0;
    end else begin
      if (awvalid && awready) begin
        aw_have_reg <= 1'b1;
        aw_addr_reg <= awaddr;
        awready <= 1'b0;
      end else if (!aw_have_reg) begin
        awready <= 1'b1;
      end
      if (wvalid && wready) begin
        w_have_reg <= 1'b1;
        w_data_reg <= wdata[15:0];
        w_strb_reg <= wstrb[1:0];
        wready <= 1'b0;
      end else if (!w_have_reg) begin
        wready <= 1'b1;
      end
      if (wr_fire) begin
        aw_have_reg <= 1'b0;
        w_have_reg <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (reg_idx(aw_addr_reg) > IDX_CTL) ? RESP_SLVERR : RESP_OKAY;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // axi read channel
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= RESP_OKAY;
    end else if (ar_take) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rresp <= RESP_OKAY;
      case (reg_idx(araddr))
        IDX_STATUS: rdata <= {16'h0000, status_word};
        IDX_LASTCMD: rdata <= {16'h0000, last_command_reg}; // R05
        IDX_SST: rdata <= 32'h0000_0000;
        IDX_PBC: rdata <= {16'h0000, pointer_base_config_reg};
        IDX_CTL: rdata <= {30'h0, b_mode_reg, self_test_enable_reg};
        default:
        begin
          rdata <= 32'h0000_0000;
          rresp <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // host-written configuration
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      pointer_base_config_reg <= PBC_RESET;
      self_test_enable_reg <= 1'b0;
      b_mode_reg <= 1'b0;
    end else if (sst_hit) begin
      self_test_enable_reg <= 1'b0; // R07
    end else if (wr_fire) begin
      if (reg_idx(aw_addr_reg) == IDX_PBC) begin
        if (w_strb_reg[0])
          pointer_base_config_reg[7:0] <= w_data_reg[7:0];
        if (w_strb_reg[1])
          pointer_base_config_reg[15:8] <= w_data_reg[15:8];
      end
      if (reg_idx(aw_addr_reg) == IDX_CTL && w_strb_reg[0]) begin
        self_test_enable_reg <= w_data_reg[CTL_ST_ENABLE];
        b_mode_reg <= w_data_reg[CTL_BMODE];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      self_test_active_reg <= 1'b0;
    else if (sst_hit)
      self_test_active_reg <= 1'b0; // R07
    else
      self_test_active_reg <= self_test_enable_reg;
  end

  // a fresh overrun wins over the clearing read
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      overrun_reg <= 1'b0;
    else if (overrun_detect)
      overrun_reg <= 1'b1; // R01
    else if (ar_take && reg_idx(araddr) == IDX_STATUS)
      overrun_reg <= 1'b0; // R02
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      last_command_reg <= LASTCMD_RESET; // R04
    else if (cmd_take && !cmd_is_tlc)
      last_command_reg <= cmd_word; // R03
  end

  // dma sequencer over the 64K-word shared memory
  always_ff @(posedge aclk)
  begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      dma_req <= 1'b0;
      dma_we <= 1'b0;
      dma_addr <= 16'h0000;
      dma_wdata <= 16'h0000;
      cur_cmd_reg <= 16'h0000;
      work_ptr_reg <= 16'h0000;
      words_left_reg <= 6'h00;
      rx_word_ready <= 1'b0;
      tx_word_valid <= 1'b0;
      tx_word <= 16'h0000;
    end else if (sst_hit) begin
      state_reg <= ST_IDLE; // R06
      dma_req <= 1'b0;
      rx_word_ready <= 1'b0;
      tx_word_valid <= 1'b0;
    end else begin
      tx_word_valid <= 1'b0;
      case (state_reg)
        ST_IDLE:
        begin
          if (cmd_take) begin
            cur_cmd_reg <= cmd_word;
            state_reg <= cmd_is_tlc ? ST_PTR_RD : ST_CMD_WR;
            dma_req <= 1'b1;
            dma_we <= !cmd_is_tlc;
            dma_wdata <= cmd_word;
            // the tlc slot is the mode slot; others store the command
            dma_addr <= {block_base, cmd_is_tlc ? SLOT_MODE : SLOT_CMD}; // R15
          end
        end
        ST_CMD_WR:
        begin
          if (dma_ack) begin
            dma_req <= cur_need_ptr;
            dma_we <= 1'b0;
            dma_addr <= {block_base, cur_slot}; // R12
            state_reg <= cur_need_ptr ? ST_PTR_RD : ST_IDLE;
          end
        end
        ST_PTR_RD:
        begin
          if (dma_ack) begin
            dma_req <= 1'b0;
            state_reg <= ST_XFER;
            rx_word_ready <= !cur_tx;
            if (cur_mode) begin
              work_ptr_reg <= {dma_rdata[15:4], cur_cmd_reg[3:0]}; // R17
              words_left_reg <= 6'h01;
            end else begin
              work_ptr_reg <= dma_rdata;
              words_left_reg <= (cur_cmd_reg[CMD_MC_MSB:0] == 5'h00) ?
                                MAX_WORDS : {1'b0, cur_cmd_reg[4:0]};
            end
          end
        end
        ST_XFER:
        begin
          if (dma_ack) begin
            dma_req <= 1'b0;
            tx_word_valid <= cur_tx;
            tx_word <= cur_tx ? dma_rdata : tx_word;
            // receive pointers wrap inside the buffer size
            work_ptr_reg <= cur_tx ? work_ptr_reg + 16'h1 // R18
                            : ring_inc(work_ptr_reg, size_exp); // R20 R21
            words_left_reg <= words_left_reg - 6'h01;
            if (words_left_reg == 6'h01) begin
              rx_word_ready <= 1'b0;
              state_reg <= cur_wb ? ST_PTR_WR : ST_IDLE;
              dma_req <= cur_wb;
              dma_we <= 1'b1;
              dma_addr <= {block_base, cur_slot}; // R16
              dma_wdata <= ring_inc(work_ptr_reg, size_exp);
            end else begin
              rx_word_ready <= !cur_tx;
            end
          end else if (!dma_req) begin
            if (cur_tx) begin
              dma_req <= 1'b1; // R09
              dma_we <= 1'b0;
              dma_addr <= work_ptr_reg;
            end else if (rx_word_valid && rx_word_ready) begin
              rx_word_ready <= 1'b0;
              dma_req <= 1'b1;
              dma_we <= 1'b1;
              dma_addr <= work_ptr_reg;
              dma_wdata <= rx_word;
            end
          end
        end
        ST_PTR_WR:
        begin
          if (dma_ack) begin
            dma_req <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          dma_req <= 1'b0;
        end
      endcase
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_cmd_store;
    cmd_take && !cmd_is_tlc;
  endsequence
  sequence s_slot0_write;
    dma_req && dma_we && dma_addr == {block_base, SLOT_CMD};
  endsequence

  chk_overrun_set: assert property ( // R01
    overrun_detect |=> overrun_reg[*2] or (overrun_reg ##1 1'b1))
    else $error("overrun not flagged");
  chk_overrun_clear: assert property ( // R02
    ar_take && reg_idx(araddr) == IDX_STATUS && !overrun_detect
    |=> !overrun_reg)
    else $error("overrun not cleared by status read");
  chk_lastcmd_capture: assert property ( // R03
    s_cmd_store |=> last_command_reg == $past(cmd_word))
    else $error("command not captured");
  chk_lastcmd_keep: assert property ( // R03
    cmd_take && cmd_is_tlc |=> $stable(last_command_reg))
    else $error("tlc overwrote last command");
  chk_lastcmd_reset: assert property ( // R04
    !$past(aresetn) |-> last_command_reg == LASTCMD_RESET)
    else $error("bad last command reset value");
  chk_cmd_slot_zero: assert property ( // R15
    s_cmd_store |=> s_slot0_write)
    else $error("command not written to slot zero");
  chk_stop_halts: assert property ( // R06
    sst_hit |=> !dma_req && state_reg == ST_IDLE ##1 !dma_req)
    else $error("memory activity after stop");
  chk_stop_clears: assert property ( // R07
    sst_hit |=> !self_test_enable_reg && !self_test_active_reg)
    else $error("self test bits not cleared");
  chk_base_upper: assert property ( // R12
    dma_req && state_reg inside {ST_PTR_RD, ST_PTR_WR}
    |-> dma_addr[15:PBC_BASE_LSB] == block_base)
    else $error("pointer address base wrong");
  chk_single_slot: assert property ( // R16
    dma_req && state_reg == ST_PTR_RD && single_mode && !cur_tx
    && !cur_mode |-> dma_addr[5:0] == SLOT_SINGLE)
    else $error("single mode slot wrong");
  chk_tx_increment: assert property ( // R18
    state_reg == ST_XFER && dma_ack && cur_tx && words_left_reg != 6'h01
    |=> work_ptr_reg == $past(work_ptr_reg) + 16'h1 ##1 dma_req)
    else $error("transmit pointer not incremented");
endmodule : rt_pointer_block_addressing

// ===== dv/shared_mem_model.sv
// shared memory that answers the dma master after a set latency
`timescale 1ns/1ns
module shared_mem_model
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // dma slave side
  input wire logic dma_req,
  input wire logic dma_we,
  input wire logic [15:0] dma_addr,
  input wire logic [15:0] dma_wdata,
  input wire logic [3:0] lat,
  output logic dma_ack,
  output logic [15:0] dma_rdata
);
  logic [15:0] mem [0:65535];
  logic [3:0] cnt;
  // read data only means something with ack; scrambled otherwise
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      dma_ack <= 1'b0;
      cnt <= 4'h0;
      dma_rdata <= 16'h0000;
    end
    else if (dma_req && !dma_ack && cnt >= lat)
    begin
      dma_ack <= 1'b1;
      cnt <= 4'h0;
      if (dma_we)
        mem[dma_addr] <= dma_wdata;
      else
        dma_rdata <= mem[dma_addr];
    end
    else
    begin
      dma_ack <= 1'b0;
      cnt <= (dma_req && !dma_ack) ? cnt + 4'h1 : 4'h0;
      dma_rdata <= ~dma_rdata;
    end
  end
endmodule : shared_mem_model

// ===== dv/tb_top.sv
// testbench for the pointer block engine and its register port
`timescale 1ns/1ns
module tb_top
  import rt_pointer_pkg::*;
();
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [4:0] awaddr = 5'h00, araddr = 5'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0, cmd_valid = 1'b0;
  logic overrun_detect = 1'b0, rx_word_valid = 1'b1;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'h0, lat = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, rx_word_ready;
  logic tx_word_valid, dma_req, dma_we, dma_ack;
  logic [1:0] bresp, rresp, rsp;
  logic [15:0] cmd_word = 16'h0, rx_word = 16'h0;
  logic [15:0] tx_word, dma_addr, dma_wdata, dma_rdata;
  logic [15:0] txq [$];
  int fails = 0, check_count = 0;
  always #2 aclk = ~aclk;
  rt_pointer_block_addressing DUT (.aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
    .overrun_detect(overrun_detect), .rx_word_valid(rx_word_valid),
    .rx_word(rx_word), .rx_word_ready(rx_word_ready),
    .tx_word_valid(tx_word_valid), .tx_word(tx_word), .dma_req(dma_req),
    .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
    .dma_ack(dma_ack), .dma_rdata(dma_rdata));
  shared_mem_model tm (.aclk(aclk), .aresetn(aresetn), .dma_req(dma_req),
    .dma_we(dma_we), .dma_addr(dma_addr), .dma_wdata(dma_wdata),
    .lat(lat), .dma_ack(dma_ack), .dma_rdata(dma_rdata));
  // receive words count up so each stored word is traceable
  always @(posedge aclk)
  begin
    if (rx_word_valid && rx_word_ready)
      rx_word <= rx_word + 16'h0001;
    if (tx_word_valid)
      txq.push_back(tx_word);
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      fails++;
      $display("[ERR] %0t wait ran out", $time);
      stop_test();
    end
  endtask : tmo
  task automatic axi_wr(input logic [4:0] a, input logic [31:0] d,
                        input logic [3:0] s);
    int n;
    logic aw_p, w_p;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    n = 0;
    while (n < 200)
    begin
      @(posedge aclk);
      n++;
      if (!aw_p && !w_p && bvalid)
        break;
      if (aw_p && awready)
      begin
        awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && wready)
      begin
        wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    bready <= 1'b0;
    rsp = bresp;
    tmo(n);
  endtask : axi_wr
  task automatic axi_rd(input logic [4:0] a);
    int n;
    logic ar_p;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    ar_p = 1'b1;
    n = 0;
    while (n < 200)
    begin
      @(posedge aclk);
      n++;
      if (!ar_p && rvalid)
        break;
      if (ar_p && arready)
      begin
        arvalid <= 1'b0;
        ar_p = 1'b0;
      end
    end
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    tmo(n);
  endtask : axi_rd
  task automatic send_cmd(input logic [15:0] w);
    int n;
    n = 0;
    do
    begin
      axi_rd({IDX_STATUS, 2'b00});
      n++;
    end
    while (rd[STAT_MSG_ACTIVE] !== 1'b0 && n < 200);
    tmo(n);
    if (w == 16'h0000)
      return;
    @(posedge aclk);
    cmd_word <= w;
    cmd_valid <= 1'b1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    send_cmd(16'h0000);
  endtask : send_cmd
  task automatic t_reset;
    axi_rd({IDX_LASTCMD, 2'b00});
    chk(rd[15:0], 16'h0410);
    axi_wr({IDX_LASTCMD, 2'b00}, 32'h0000_ffff, 4'hf);
    chk(16'(rsp), 16'(RESP_OKAY));
    axi_rd({IDX_LASTCMD, 2'b00});
    chk(rd[15:0], 16'h0410);
    axi_rd(5'h14);
    chk(16'(rsp), 16'(RESP_SLVERR));
    // unmapped write: refused on the response channel
    axi_wr(5'h18, 32'h0000_0001, 4'hf);
    chk(16'(rsp), 16'(RESP_SLVERR));
    $display("test reset done");
  endtask : t_reset
  task automatic t_overrun;
    @(posedge aclk);
    overrun_detect <= 1'b1;
    @(posedge aclk);
    overrun_detect <= 1'b0;
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_OVERRUN]), 16'h1);
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_OVERRUN]), 16'h0);
    overrun_detect <= 1'b1;
    axi_rd({IDX_STATUS, 2'b00});
    overrun_detect <= 1'b0;
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_OVERRUN]), 16'h1);
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_OVERRUN]), 16'h0);
    $display("test overrun done");
  endtask : t_overrun
  task automatic t_rx_sep;
    logic [15:0] w0;
    w0 = rx_word;
    tm.mem[16'ha943] = 16'h123f;
    // smallest ring: one word lands on the last slot, then wraps
    axi_wr({IDX_PBC, 2'b00}, 32'h0000_a943, 4'h3);
    axi_rd({IDX_PBC, 2'b00});
    chk(rd[15:0], 16'ha943);
    send_cmd({5'h05, 1'b0, 5'h03, 5'h01});
    chk(tm.mem[16'ha940], 16'h2861);
    chk(tm.mem[16'h123f], w0);
    chk(tm.mem[16'ha943], 16'h1238);
    axi_rd({IDX_LASTCMD, 2'b00});
    chk(rd[15:0], 16'h2861);
    $display("test rx_sep done");
  endtask : t_rx_sep
  task automatic t_rx_single;
    logic [15:0] w0;
    w0 = rx_word;
    lat <= 4'h3;
    tm.mem[16'h401f] = 16'h5ffe;
    tm.mem[16'h4007] = 16'h7777;
    axi_wr({IDX_PBC, 2'b00}, 32'h0000_4014, 4'h3);
    send_cmd({5'h05, 1'b0, 5'h07, 5'h02});
    chk(tm.mem[16'h5ffe], w0);
    chk(tm.mem[16'h5fff], w0 + 16'h0001);
    chk(tm.mem[16'h401f], 16'h5ff0);
    chk(tm.mem[16'h4007], 16'h7777);
    $display("test rx_single done");
  endtask : t_rx_single
  task automatic t_tx;
    lat <= 4'h1;
    tm.mem[16'h4022] = 16'h3000;
    for (int i = 0; i < 3; i++)
      tm.mem[16'h3000 + 16'(i)] = 16'hc0d0 + 16'(i);
    txq.delete();
    send_cmd({5'h05, 1'b1, 5'h02, 5'h03});
    chk(16'(txq.size()), 16'h3);
    for (int i = 0; i < 3 && i < txq.size(); i++)
      chk(txq[i], 16'hc0d0 + 16'(i));
    chk(tm.mem[16'h4022], 16'h3000);
    // word count zero asks for a full 32-word message
    tm.mem[16'h4023] = 16'h3100;
    for (int i = 0; i < 32; i++)
      tm.mem[16'h3100 + 16'(i)] = 16'hd000 + 16'(i);
    txq.delete();
    send_cmd({5'h05, 1'b1, 5'h03, 5'h00});
    chk(16'(txq.size()), 16'h20);
    if (txq.size() == 32)
      chk(txq[31], 16'hd01f);
    chk(tm.mem[16'h4023], 16'h3100);
    $display("test tx done");
  endtask : t_tx
  task automatic t_mode;
    logic [15:0] w0;
    w0 = rx_word;
    tm.mem[16'h4020] = 16'h6ab7;
    tm.mem[16'h6ab1] = 16'h0000;
    // 1553A knows no mode code with data: only the store happens
    send_cmd({5'h05, 1'b0, 5'h1f, 5'h11});
    chk(tm.mem[16'h6ab1], 16'h0000);
    chk(tm.mem[16'h4000], 16'h2bf1);
    axi_wr({IDX_CTL, 2'b00}, 32'h0000_0002, 4'h1);
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_BMODE]), 16'h1);
    send_cmd({5'h05, 1'b0, 5'h1f, 5'h11});
    chk(tm.mem[16'h6ab1], w0);
    chk(tm.mem[16'h4000], 16'h2bf1);
    send_cmd({5'h05, 1'b1, 5'h00, 5'h12});
    axi_rd({IDX_LASTCMD, 2'b00});
    chk(rd[15:0], 16'h2bf1);
    chk(tm.mem[16'h4000], 16'h2bf1);
    // mode code without data: command store only, nothing sent
    txq.delete();
    send_cmd({5'h05, 1'b1, 5'h00, 5'h02});
    chk(tm.mem[16'h4000], 16'h2c02);
    chk(16'(txq.size()), 16'h0);
    axi_rd({IDX_LASTCMD, 2'b00});
    chk(rd[15:0], 16'h2c02);
    $display("test mode done");
  endtask : t_mode
  task automatic t_sst;
    axi_wr({IDX_CTL, 2'b00}, 32'h0000_0001, 4'h1);
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_ST_ACTIVE]), 16'h1);
    lat <= 4'hf;
    @(posedge aclk);
    cmd_word <= {5'h05, 1'b1, 5'h02, 5'h00};
    cmd_valid <= 1'b1;
    @(posedge aclk);
    cmd_valid <= 1'b0;
    // zero strobes and junk data: only the access counts
    axi_wr({IDX_SST, 2'b00}, 32'h0000_5a5a, 4'h0);
    repeat (8)
    begin
      @(posedge aclk);
      chk(16'(dma_req), 16'h0);
    end
    axi_rd({IDX_CTL, 2'b00});
    chk(16'(rd[CTL_ST_ENABLE]), 16'h0);
    axi_rd({IDX_STATUS, 2'b00});
    chk(16'(rd[STAT_ST_ACTIVE]), 16'h0);
    chk(16'(rd[STAT_MSG_ACTIVE]), 16'h0);
    $display("test sst done");
  endtask : t_sst
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_overrun();
    t_rx_sep();
    t_rx_single();
    t_tx();
    t_mode();
    t_sst();
    stop_test();
  end
endmodule : tb_top
